// >>> design/lsc_clock_select.sv
// The implementer's own choices: the AXI4-Lite register port and the register offsets.
`default_nettype none
// Contract
// RL1: slow source code 0101010 picks RC, 1010101 picks crystal, others request reset.
// RL2: bit 7 of slow control sets crystal quick-start (0) or low-power (1).
// RL3: crystal low-power bit is cleared by reset, crystal starts quick.
// RL4: low-power crystal keeps running normally, only its start-up is slower.
// RL5: software should set low-power about two seconds after power-on.
// RL6: crystal start-up delay elapses before it counts as a usable clock.
// RL7: crystal pins are freed for general use when crystal is not selected.
// RL8: system clock picks fast or slow via direct-fast and divider bits.
// RL9: fast clock comes from external crystal or internal RC high oscillator.
// RL10: slow clock comes from crystal or RC low oscillator per source code.
// RL11: divided fast options range from fast/2 down to fast/64.
// RL12: moving the system clock to slow stops the high-speed oscillator.
// RL13: halt stops system clock; slow clock may keep running for timers. Here idle_keep_sysclk high keeps the system clock running in halt.
// RL14: divider 000/001 slow, 010..111 give fast/64,/32,/16,/8,/4,/2.
// RL15: direct-fast 1 uses undivided fast clock, 0 uses divider selection.
// RL16: ready flag rises 1024 crystal cycles or 2 RC cycles after wake.
// RL17: system clock source switches without truncated pulses or glitches.
module lsc_clock_select
    import lsc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [LSC_ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [LSC_ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic ext_low_crystal_osc,
    input wire logic int_low_rc_osc,
    input wire logic ext_high_crystal_osc,
    input wire logic int_high_rc_osc,
    input wire logic fast_from_crystal,
    input wire logic cpu_halt,
    input wire logic idle_keep_sysclk,
    input wire logic slow_stop,
    input wire logic wake,
    output logic system_clock,
    output logic slow_clock,
    output logic fast_osc_enable,
    output logic crystal_low_power_bit,
    output logic low_crystal_pins_osc,
    output logic idle_enable,
    output logic low_osc_ready_flag,
    output logic mcu_reset_req
);
    // ********************************************************
    // decode helpers
    // ********************************************************
    function automatic lsc_src_e src_of(input logic [3:0] sel);
        if (sel[3]) begin
            return LSC_SRC_FAST; // see RL15
        end else if (sel[2:1] == 2'h0) begin
            return LSC_SRC_SLOW; // see RL14
        end else begin
            return LSC_SRC_DIV;
        end
    endfunction

    // sel = {direct_fast_select, system_clock_divider_select}
    function automatic logic pulse_of(input logic [3:0] sel, input logic fast,
                                      input logic [5:0] taps, input logic slow);
        logic [2:0] idx;
        idx = 3'h7 - sel[2:0];
        unique case (src_of(sel))
            LSC_SRC_FAST: return fast;
            LSC_SRC_SLOW: return slow;
            LSC_SRC_DIV: return taps[idx]; // see RL14
        endcase
    endfunction

    function automatic logic code_ok(input logic [6:0] code);
        return (code == LSC_CODE_RC) || (code == LSC_CODE_XT);
    endfunction

    // ********************************************************
    // registers and AXI4-Lite slave
    // ********************************************************
    logic [7:0] slow_ctrl_ff;
    logic [7:0] mode_ctrl_ff;
    logic aw_held_ff;
    logic w_held_ff;
    logic [LSC_ADDR_W-1:0] aw_addr_ff;
    logic [31:0] w_data_ff;
    logic [3:0] w_strb_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    logic wr_go;
    logic wr_slow;
    logic wr_mode;
    logic ready_ff;
    logic fast_on_ff;

    assign s_axi_awready = !aw_held_ff;
    assign s_axi_wready = !w_held_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = !rvalid_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;

    // address and data are taken in either order, the write happens once both are in
    assign wr_go = aw_held_ff && w_held_ff && !bvalid_ff;
    assign wr_slow = wr_go && aw_addr_ff == LSC_OFS_SLOW_CTRL && w_strb_ff[0];
    assign wr_mode = wr_go && aw_addr_ff == LSC_OFS_MODE_CTRL && w_strb_ff[0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_ff <= 1'b0;
            aw_addr_ff <= '0;
        end else if (s_axi_awvalid && !aw_held_ff) begin
            aw_held_ff <= 1'b1;
            aw_addr_ff <= s_axi_awaddr;
        end else if (wr_go) begin
            aw_held_ff <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_ff <= 1'b0;
            w_data_ff <= 32'h0000_0000;
            w_strb_ff <= 4'h0;
        end else if (s_axi_wvalid && !w_held_ff) begin
            w_held_ff <= 1'b1;
            w_data_ff <= s_axi_wdata;
            w_strb_ff <= s_axi_wstrb;
        end else if (wr_go) begin
            w_held_ff <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= LSC_RESP_OKAY;
        end else if (wr_go) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= (aw_addr_ff == LSC_OFS_SLOW_CTRL || aw_addr_ff == LSC_OFS_MODE_CTRL)
                        ? LSC_RESP_OKAY : LSC_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    // reset leaves the crystal in quick-start mode
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            slow_ctrl_ff <= LSC_SLOW_CTRL_RST; // see RL3
        end else if (wr_slow) begin
            slow_ctrl_ff <= w_data_ff[7:0]; // see RL2
        end
    end

    // only divider, idle and direct bits are writable; flags are live state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_ctrl_ff <= LSC_MODE_CTRL_RST;
        end else if (wr_mode) begin
            mode_ctrl_ff <= {w_data_ff[7:5], 3'h0, w_data_ff[1:0]};
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= LSC_RESP_OKAY;
        end else if (s_axi_arvalid && !rvalid_ff) begin
            rvalid_ff <= 1'b1;
            rresp_ff <= LSC_RESP_OKAY;
            rdata_ff <= 32'h0000_0000;
            if (s_axi_araddr == LSC_OFS_SLOW_CTRL) begin
                rdata_ff[7:0] <= slow_ctrl_ff;
            end else if (s_axi_araddr == LSC_OFS_MODE_CTRL) begin
                rdata_ff[7:0] <= {mode_ctrl_ff[7:5], 1'b0, ready_ff, fast_on_ff,
                                  mode_ctrl_ff[1:0]};
            end else begin
                rresp_ff <= LSC_RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    // ********************************************************
    // slow clock source and start-up
    // ********************************************************
    logic use_xt;
    logic slow_raw;
    logic [10:0] ready_cnt_ff;
    logic [10:0] ready_target;
    logic prev_xt_ff;

    assign use_xt = slow_ctrl_ff[6:0] == LSC_CODE_XT;
    assign slow_raw = (use_xt ? ext_low_crystal_osc : int_low_rc_osc) && !slow_stop; // see RL10
    assign ready_target = use_xt ? LSC_XT_READY_TICKS : LSC_RC_READY_TICKS;
    assign low_crystal_pins_osc = use_xt; // see RL7
    // low-power changes only crystal bias; clocking logic treats both modes alike
    assign crystal_low_power_bit = slow_ctrl_ff[LSC_LP_BIT]; // see RL2, RL4
    assign low_osc_ready_flag = ready_ff;
    assign idle_enable = mode_ctrl_ff[LSC_IDLE_BIT];
    assign slow_clock = slow_raw && ready_ff; // see RL6

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev_xt_ff <= 1'b0;
        end else begin
            prev_xt_ff <= use_xt;
        end
    end

    // a source change restarts start-up, the new oscillator is not yet proven
    always_ff @(posedge aclk) begin
        if (!aresetn || wake || slow_stop || prev_xt_ff != use_xt) begin
            ready_cnt_ff <= 11'h000;
            ready_ff <= 1'b0;
        end else if (slow_raw && !ready_ff) begin
            if (ready_cnt_ff == ready_target - 11'h001) begin
                ready_ff <= 1'b1; // see RL16
            end else begin
                ready_cnt_ff <= ready_cnt_ff + 11'h001;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mcu_reset_req <= 1'b0;
        end else begin
            mcu_reset_req <= !code_ok(slow_ctrl_ff[6:0]); // see RL1
        end
    end

    // ********************************************************
    // fast clock and system clock switch
    // ********************************************************
    lsc_div_if div_bus();
    lsc_sw_e sw_ff;
    logic [3:0] active_sel_ff;
    logic [3:0] pend_sel;
    logic sys_gate;
    logic fast_tick;
    logic old_pulse;
    logic nxt_fast_on;

    assign pend_sel = {mode_ctrl_ff[LSC_DIRECT_BIT], mode_ctrl_ff[7:LSC_DIV_LSB]}; // see RL8
    assign sys_gate = cpu_halt && !idle_keep_sysclk; // see RL13
    assign fast_tick = (fast_from_crystal ? ext_high_crystal_osc : int_high_rc_osc)
                       && fast_on_ff; // see RL9
    assign div_bus.fast_tick = fast_tick;
    assign old_pulse = pulse_of(active_sel_ff, fast_tick, div_bus.div_tick, slow_clock);
    assign system_clock = old_pulse && !sys_gate; // see RL13
    assign fast_osc_enable = fast_on_ff;
    // restart the prescaler on the hand-over so the first divided period is whole
    assign div_bus.clear = sw_ff == LSC_SW_DRAIN && (old_pulse || sys_gate);

    lsc_fast_div u_div (
        .aclk(aclk),
        .aresetn(aresetn),
        .div(div_bus)
    );

    // hand over only right after a pulse of the old source or while halt gates the system clock; no short period results
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sw_ff <= LSC_SW_RUN;
            active_sel_ff <= {LSC_MODE_CTRL_RST[LSC_DIRECT_BIT], LSC_MODE_CTRL_RST[7:5]};
        end else begin
            unique case (sw_ff)
                LSC_SW_RUN: begin
                    if (pend_sel != active_sel_ff) begin
                        sw_ff <= LSC_SW_DRAIN;
                    end
                end
                LSC_SW_DRAIN: begin
                    if (old_pulse || sys_gate) begin
                        active_sel_ff <= pend_sel; // see RL17
                        sw_ff <= LSC_SW_RUN;
                    end
                end
            endcase
        end
    end

    // fast oscillator runs while the active or pending choice needs it and halt does not gate the system clock
    always_comb begin
        nxt_fast_on = (src_of(active_sel_ff) != LSC_SRC_SLOW
                       || src_of(pend_sel) != LSC_SRC_SLOW) && !sys_gate; // see RL12
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fast_on_ff <= 1'b1;
        end else begin
            fast_on_ff <= nxt_fast_on;
        end
    end

    // ********************************************************
    // assertions
    // ********************************************************
    sequence s_bad_write;
        wr_slow && !code_ok(w_data_ff[6:0]);
    endsequence

    sequence s_ready_rise;
        $rose(ready_ff);
    endsequence

    a_bad_code_reset: assert property (@(posedge aclk) disable iff (!aresetn) // see RL1
        s_bad_write |-> ##2 mcu_reset_req)
        else $error("invalid slow source code did not request reset");

    a_lp_bit_write: assert property (@(posedge aclk) disable iff (!aresetn) // see RL2
        $changed(crystal_low_power_bit) |-> $past(wr_slow))
        else $error("low-power bit changed without a register write");

    a_lp_reset_zero: assert property (@(posedge aclk) // see RL3
        $past(!aresetn) |-> !crystal_low_power_bit)
        else $error("low-power bit not cleared by reset");

    a_ready_count: assert property (@(posedge aclk) disable iff (!aresetn) // see RL16
        s_ready_rise |-> $past(slow_raw) && $past(ready_cnt_ff) == $past(ready_target) - 11'h001)
        else $error("ready flag rose at the wrong start-up count");

    a_slow_needs_ready: assert property (@(posedge aclk) disable iff (!aresetn) // see RL6
        slow_clock |-> ready_ff && !slow_stop)
        else $error("slow clock emitted before start-up elapsed");

    a_fast_stops: assert property (@(posedge aclk) disable iff (!aresetn) // see RL12
        src_of(active_sel_ff) == LSC_SRC_SLOW && src_of(pend_sel) == LSC_SRC_SLOW
        ##1 src_of(pend_sel) == LSC_SRC_SLOW |-> !fast_osc_enable)
        else $error("fast oscillator left running with slow system clock");

    a_halt_gates: assert property (@(posedge aclk) disable iff (!aresetn) // see RL13
        cpu_halt && !idle_keep_sysclk |-> !system_clock ##1 !fast_osc_enable)
        else $error("system clock ran during halt");

    a_direct_fast: assert property (@(posedge aclk) disable iff (!aresetn) // see RL15
        active_sel_ff[3] && fast_tick && !sys_gate |-> system_clock)
        else $error("direct fast selection did not pass the fast clock");

    a_clean_switch: assert property (@(posedge aclk) disable iff (!aresetn) // see RL17
        $changed(active_sel_ff) |-> $past(old_pulse) || $past(sys_gate))
        else $error("clock source switched in mid period");

    a_pins_follow: assert property (@(posedge aclk) disable iff (!aresetn) // see RL7
        wr_slow && w_data_ff[6:0] != LSC_CODE_XT |=> !low_crystal_pins_osc)
        else $error("crystal pins kept after crystal deselected");
endmodule
`default_nettype wire

// >>> design/lsc_pkg.sv
`default_nettype none
package lsc_pkg;
    // ********************************************************
    // register map (byte addresses, one aligned word each)
    // ********************************************************
    localparam int LSC_ADDR_W = 4;
    localparam logic [LSC_ADDR_W-1:0] LSC_OFS_SLOW_CTRL = 4'h0;
    localparam logic [LSC_ADDR_W-1:0] LSC_OFS_MODE_CTRL = 4'h4;

    // ********************************************************
    // fields and reset values
    // ********************************************************
    localparam logic [7:0] LSC_SLOW_CTRL_RST = 8'h2A;
    localparam logic [7:0] LSC_MODE_CTRL_RST = 8'h03;
    localparam int LSC_LP_BIT = 7;
    localparam int LSC_DIV_LSB = 5;
    localparam int LSC_READY_BIT = 3;
    localparam int LSC_FAST_RDY_BIT = 2;
    localparam int LSC_IDLE_BIT = 1;
    localparam int LSC_DIRECT_BIT = 0;
    localparam logic [6:0] LSC_CODE_RC = 7'h2A;
    localparam logic [6:0] LSC_CODE_XT = 7'h55;
    localparam logic [1:0] LSC_RESP_OKAY = 2'h0;
    localparam logic [1:0] LSC_RESP_SLVERR = 2'h2;

    // ********************************************************
    // start-up counts, in cycles of the selected slow source
    // ********************************************************
    localparam logic [10:0] LSC_XT_READY_TICKS = 11'h400;
    localparam logic [10:0] LSC_RC_READY_TICKS = 11'h002;

    typedef enum logic [1:0] {LSC_SRC_SLOW, LSC_SRC_DIV, LSC_SRC_FAST} lsc_src_e;
    typedef enum logic {LSC_SW_RUN, LSC_SW_DRAIN} lsc_sw_e;
endpackage
`default_nettype wire

// >>> design/lsc_div_if.sv
`default_nettype none
interface lsc_div_if;
    logic fast_tick;
    logic clear;
    logic [5:0] div_tick;
    modport src(input fast_tick, input clear, output div_tick);
    modport user(output fast_tick, output clear, input div_tick);
endinterface
`default_nettype wire

// >>> design/lsc_fast_div.sv
`default_nettype none
// ********************************************************
// fast clock prescaler: div_tick[k] marks every 2^(k+1)-th fast tick
// ********************************************************
module lsc_fast_div
    import lsc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    lsc_div_if.src div
);
    logic [5:0] cnt_ff;

    // clear restarts every phase so a newly chosen ratio gets a full first period
    always_ff @(posedge aclk) begin
        if (!aresetn || div.clear) begin
            cnt_ff <= 6'h00;
        end else if (div.fast_tick) begin
            cnt_ff <= cnt_ff + 6'h01;
        end
    end

    genvar k;
    generate
        for (k = 0; k < 6; k++) begin : g_tap
            assign div.div_tick[k] = div.fast_tick && (&cnt_ff[k:0]); // see RL11
        end
    endgenerate

    a_div_wrap: assert property (@(posedge aclk) disable iff (!aresetn) // see RL11
        div.div_tick[5] && !div.clear |=> cnt_ff == 6'h00)
        else $error("divide by 64 tap did not wrap the prescaler");
endmodule
`default_nettype wire

// >>> bench/low_speed_clock_select_tb.sv
`default_nettype none
module low_speed_clock_select_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import lsc_pkg::*;

    logic aclk = 1'b0;
    logic aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [LSC_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [2:0] s_axi_awprot, s_axi_arprot;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic ext_low_crystal_osc, int_low_rc_osc, ext_high_crystal_osc, int_high_rc_osc;
    logic fast_from_crystal, cpu_halt, idle_keep_sysclk, slow_stop, wake;
    logic system_clock, slow_clock, fast_osc_enable, crystal_low_power_bit;
    logic low_crystal_pins_osc, idle_enable, low_osc_ready_flag, mcu_reset_req;
    logic fast_now;
    logic [1:0] cyc = 2'h0;
    logic [31:0] lfsr = 32'hFE3D0676;
    int num_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    int tick_cnt = 0;
    int last_per = 0;
    int pulses = 0;

    lsc_clock_select dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .ext_low_crystal_osc, .int_low_rc_osc, .ext_high_crystal_osc,
        .int_high_rc_osc, .fast_from_crystal, .cpu_halt, .idle_keep_sysclk, .slow_stop,
        .wake, .system_clock, .slow_clock, .fast_osc_enable, .crystal_low_power_bit,
        .low_crystal_pins_osc, .idle_enable, .low_osc_ready_flag, .mcu_reset_req);

    always #10 aclk = ~aclk;

    // ****************************************
    // oscillator ticks, timeout, period monitor
    // ****************************************
    // sources tick at different rates and phases so a wrong pick shows up in counts
    assign fast_now = fast_from_crystal ? ext_high_crystal_osc : int_high_rc_osc;

    always @(posedge aclk) begin
        cyc <= cyc + 2'h1;
        ext_high_crystal_osc <= cyc[0];
        int_high_rc_osc <= (cyc == 2'h1);
        ext_low_crystal_osc <= (cyc == 2'h2);
        int_low_rc_osc <= (cyc == 2'h0);
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            num_errors++;
            complete_run();
        end
    end

    // fast ticks between system clock pulses, the pulse cycle included
    always @(posedge aclk) begin
        if (system_clock) begin
            last_per <= tick_cnt + int'(fast_now);
            tick_cnt <= 0;
            pulses <= pulses + 1;
        end else begin
            tick_cnt <= tick_cnt + int'(fast_now);
        end
    end

    // ****************************************
    // tasks and functions
    // ****************************************
    function automatic logic [31:0] nxt(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h0);
    endfunction

    function automatic int div_ticks(input logic [2:0] d, input logic dir);
        return dir ? 1 : (1 << (8 - int'(d)));
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [1:0] r);
        bit aw, w;
        aw = 0;
        w = 0;
        lfsr = nxt(lfsr);
        s_axi_awaddr <= a;
        s_axi_awprot <= lfsr[2:0];
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw && w)) begin
            @(posedge aclk);
            if (!aw && s_axi_awready) begin
                aw = 1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w && s_axi_wready) begin
                w = 1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        // bready stays high, so a following call never raises it in the step it fell
        r = s_axi_bresp;
    endtask

    task automatic rdreg(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        lfsr = nxt(lfsr);
        s_axi_araddr <= a;
        s_axi_arprot <= lfsr[2:0];
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask

    task automatic wait_pulses(input int k);
        int p;
        p = pulses;
        while (pulses < p + k) @(posedge aclk);
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        logic [31:0] rd;
        logic [1:0] rsp;
        logic [6:0] code;
        logic [2:0] d;
        logic lp, xt, tk, dir, idl;
        int n;
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
        {s_axi_rready, fast_from_crystal, cpu_halt, idle_keep_sysclk, slow_stop, wake} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot} = '0;
        {s_axi_wdata, s_axi_wstrb} = '0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rdreg(LSC_OFS_SLOW_CTRL, rd, rsp);
        check(rd, 32'h2A);
        check(crystal_low_power_bit, 1'b0);
        rdreg(LSC_OFS_MODE_CTRL, rd, rsp);
        check(rd & 32'hF7, 32'h07);
        wr(4'h8, 32'h55, 4'hF, rsp);
        check(rsp, LSC_RESP_SLVERR);
        rdreg(4'hC, rd, rsp);
        check({rd[29:0], rsp}, {30'h0, LSC_RESP_SLVERR});
        // a write with the low byte strobe off must leave the register alone
        wr(LSC_OFS_SLOW_CTRL, 32'hD5, 4'h0, rsp);
        rdreg(LSC_OFS_SLOW_CTRL, rd, rsp);
        check(rd, 32'h2A);
        for (int i = 0; i < 7; i++) begin
            lfsr = nxt(lfsr);
            lp = lfsr[9];
            code = (i % 3 == 0 || i == 6) ? 7'h2A : (i % 3 == 1) ? 7'h55 : lfsr[6:0];
            if (i % 3 == 2 && (code == 7'h2A || code == 7'h55)) code = code ^ 7'h01;
            xt = (code == 7'h55);
            wr(LSC_OFS_SLOW_CTRL, {24'h0, lp, code}, 4'hF, rsp);
            check(rsp, LSC_RESP_OKAY);
            repeat (2) @(posedge aclk);
            check(mcu_reset_req, (i % 3 == 2 && i != 6));
            check(crystal_low_power_bit, lp);
            check(low_crystal_pins_osc, xt);
            rdreg(LSC_OFS_SLOW_CTRL, rd, rsp);
            check(rd, {24'h0, lp, code});
            if (i % 3 != 2 || i == 6) begin
                wake <= 1'b1;
                @(posedge aclk);
                wake <= 1'b0;
                n = 0;
                forever begin
                    @(posedge aclk);
                    if (low_osc_ready_flag) break;
                    n += int'(xt ? ext_low_crystal_osc : int_low_rc_osc);
                end
                check(n, xt ? 1024 : 2);
                repeat (20) begin
                    @(posedge aclk);
                    tk = xt ? ext_low_crystal_osc : int_low_rc_osc;
                    check(slow_clock, tk);
                end
            end
        end
        for (int j = 0; j < 9; j++) begin
            lfsr = nxt(lfsr);
            d = j[2:0];
            dir = (j == 8);
            idl = lfsr[4];
            fast_from_crystal <= lfsr[7];
            wr(LSC_OFS_MODE_CTRL, {24'h0, d, 3'h0, idl, dir}, 4'hF, rsp);
            wait_pulses(3);
            check(idle_enable, idl);
            if (!dir && d < 3'h2) begin
                check(fast_osc_enable, 1'b0);
                repeat (12) begin
                    @(posedge aclk);
                    check(system_clock, int_low_rc_osc);
                end
            end else begin
                check(fast_osc_enable, 1'b1);
                check(last_per, div_ticks(d, dir));
            end
            rdreg(LSC_OFS_MODE_CTRL, rd, rsp);
            check(rd & 32'hF7, {24'h0, d, 2'h0, dir || d > 3'h1, idl, dir});
        end
        wr(LSC_OFS_MODE_CTRL, 32'h03, 4'hF, rsp);
        wait_pulses(2);
        cpu_halt <= 1'b1;
        repeat (3) @(posedge aclk);
        n = pulses;
        tk = 1'b0;
        repeat (40) begin
            @(posedge aclk);
            tk = tk | slow_clock;
        end
        check(pulses - n, 0);
        check(tk, 1'b1);
        idle_keep_sysclk <= 1'b1;
        wait_pulses(3);
        check(last_per, 1);
        idle_keep_sysclk <= 1'b0;
        slow_stop <= 1'b1;
        repeat (3) @(posedge aclk);
        check(low_osc_ready_flag, 1'b0);
        tk = 1'b0;
        repeat (20) begin
            @(posedge aclk);
            tk = tk | slow_clock;
        end
        check(tk, 1'b0);
        slow_stop <= 1'b0;
        cpu_halt <= 1'b0;
        wait_pulses(2);
        check(last_per, 1);
        complete_run();
    end
endmodule
`default_nettype wire
